// *** monitor_loop_sequencer.sv ***
`timescale 1ns/100ps
module monitor_loop_sequencer
#(
   parameter int SLOT_CYCLES = mon_pkg::SLOT_CYCLES
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // register port (from the 2-wire slave, same clock)
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   // converter results; analog side is asynchronous, so codes are double-registered
   input  wire logic [7:0] i_temperature_code,
   input  wire logic [7:0] i_standby_or_secondary_core_input,
   input  wire logic [7:0] i_supply_12v_code,
   input  wire logic [7:0] i_supply_5v_code,
   input  wire logic [7:0] i_supply_3v3_code,
   input  wire logic [7:0] i_supply_2v5_code,
   input  wire logic [7:0] i_primary_core_voltage_input,
   input  wire logic [7:0] i_tachometer_one,
   input  wire logic [7:0] i_tachometer_two,
   output logic            o_running,
   output logic [3:0]      o_channel,
   output logic            o_int_output_cleared,
   output logic            o_int_output_enable
);
   typedef struct packed {
      mon_pkg::seq_state_t st;
      logic [7:0]          config_r;
      logic [3:0]          ch;
      logic [31:0]         cnt;
      logic                we;
      logic [4:0]          waddr;
      logic [7:0]          wdata;
      logic                rd_mem;
      logic [7:0]          rdata_reg;
      logic                running;
   } state_t;

   state_t     s_r;
   state_t     s_nxt;
   logic [71:0] sync1_r;
   logic [71:0] sync2_r;
   logic [7:0]  mem_rdata;
   logic [7:0]  sample;
   logic        go;

   function automatic logic in_value_ram(input logic [7:0] a);
      in_value_ram = (a >= mon_pkg::ADDR_VALUE_BASE) && (a <= mon_pkg::ADDR_VALUE_LAST);
   endfunction

   always_ff @(posedge i_clk)
   begin
      sync1_r <= {i_tachometer_two, i_tachometer_one, i_primary_core_voltage_input,
                  i_supply_2v5_code, i_supply_3v3_code, i_supply_5v_code,
                  i_supply_12v_code, i_standby_or_secondary_core_input,
                  i_temperature_code};
      sync2_r <= sync1_r;
   end

   // codes arrive already scaled by the converter: temperature two's complement,
   // supplies unsigned with nominal at 192, core inputs 0..ffh over 0..3.60 V
   always_comb
   begin
      sample = sync2_r[8*s_r.ch +: 8];
   end

   // run bit high with clear bit low keeps the loop going
   assign go = s_r.config_r[mon_pkg::CFG_RUN_BIT] &&
               !s_r.config_r[mon_pkg::CFG_INT_CLR_BIT];

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.we = 1'b0;
      s_nxt.rd_mem = in_value_ram(i_reg_addr);
      if (i_reg_addr == mon_pkg::ADDR_CONFIG)
      begin
         s_nxt.rdata_reg = s_r.config_r;
      end
      else
      begin
         s_nxt.rdata_reg = 8'h00;
      end
      if (i_reg_wr)
      begin
         if (i_reg_addr == mon_pkg::ADDR_CONFIG)
         begin
            s_nxt.config_r = i_reg_wdata;
         end
         else if (in_value_ram(i_reg_addr))
         begin
            // host limit writes; a sequencer store below overrides them the same cycle
            s_nxt.we    = 1'b1;
            s_nxt.waddr = i_reg_addr[4:0];
            s_nxt.wdata = i_reg_wdata;
         end
      end
      case (s_r.st)
         mon_pkg::ST_IDLE:
         begin
            s_nxt.running = 1'b0;
            if (go)
            begin
               s_nxt.ch      = mon_pkg::CH_TEMPERATURE;
               s_nxt.cnt     = 32'h0;
               s_nxt.running = 1'b1;
               s_nxt.st      = mon_pkg::ST_WAIT;
            end
         end
         mon_pkg::ST_WAIT:
         begin
            if (s_r.cnt >= 32'(SLOT_CYCLES - 1))
            begin
               s_nxt.st = mon_pkg::ST_STORE;
            end
            else
            begin
               s_nxt.cnt = s_r.cnt + 32'h1;
            end
         end
         mon_pkg::ST_STORE:
         begin
            // one whole byte written in a single cycle
            s_nxt.we    = 1'b1;
            s_nxt.waddr = 5'(mon_pkg::ADDR_TEMP_SLOT + 8'(s_r.ch));
            s_nxt.wdata = sample;
            s_nxt.cnt   = 32'h0;
            if (s_r.ch == mon_pkg::NUM_CHANNELS - 4'h1)
            begin
               // stop only at loop end so a started loop always completes
               s_nxt.ch = mon_pkg::CH_TEMPERATURE;
               s_nxt.st = go ? mon_pkg::ST_WAIT : mon_pkg::ST_IDLE;
            end
            else
            begin
               s_nxt.ch = s_r.ch + 4'h1;
               s_nxt.st = mon_pkg::ST_WAIT;
            end
         end
         default:
         begin
            s_nxt.st = mon_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s_r          <= '0;
         s_r.config_r <= mon_pkg::CONFIG_RESET;
         s_r.st       <= mon_pkg::ST_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // temperature slot lands at 27h; fans follow at 2Eh and 2Fh
   value_mem #(.AW(5)) u_mem
   (
      .i_clk   (i_clk),
      .i_we    (s_r.we),
      .i_waddr (s_r.waddr),
      .i_wdata (s_r.wdata),
      .i_raddr (i_reg_addr[4:0]),
      .o_rdata (mem_rdata)
   );

   // read path is independent of the loop so host reads never stall it
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_reg_rdata          <= 8'h00;
         o_running            <= 1'b0;
         o_channel            <= 4'h0;
         o_int_output_cleared <= 1'b1;
         o_int_output_enable  <= 1'b0;
      end
      else
      begin
         o_reg_rdata          <= s_r.rd_mem ? mem_rdata : s_r.rdata_reg;
         o_running            <= s_r.running;
         o_channel            <= s_r.ch;
         o_int_output_cleared <= s_r.config_r[mon_pkg::CFG_INT_CLR_BIT];
         o_int_output_enable  <= s_r.config_r[mon_pkg::CFG_INT_EN_BIT];
      end
   end
endmodule

// *** mon_pkg.sv ***
package mon_pkg;
   localparam logic [7:0] ADDR_CONFIG      = 8'h40;
   localparam logic [7:0] CONFIG_RESET     = 8'h08;
   localparam int         CFG_RUN_BIT      = 0;
   localparam int         CFG_INT_EN_BIT   = 1;
   localparam int         CFG_INT_CLR_BIT  = 3;
   localparam logic [7:0] ADDR_VALUE_BASE  = 8'h20;
   localparam logic [7:0] ADDR_VALUE_LAST  = 8'h3d;
   localparam logic [7:0] ADDR_TEMPERATURE = 8'h27;
   localparam logic [7:0] ADDR_TEMP_SLOT   = 8'h07;
   localparam logic [3:0] NUM_CHANNELS     = 4'h9;
   localparam logic [3:0] CH_TEMPERATURE   = 4'h0;
   localparam logic [3:0] CH_TACH_ONE      = 4'h7;
   localparam int         LOOP_MS          = 1000;
   localparam int         CLK_KHZ          = 40000;
   // one loop of nine slots per second: floor of period per slot
   localparam int         SLOT_CYCLES      = (LOOP_MS * CLK_KHZ) / 9;
   localparam logic [7:0] NOMINAL_CODE     = 8'hc0;
   localparam logic [7:0] CORE_FULL_CODE   = 8'hff;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_STORE = 2'b10
   } seq_state_t;
endpackage

// *** value_mem.sv ***
`timescale 1ns/100ps
module value_mem
#(
   parameter int AW = 5
)
(
   input  wire logic          i_clk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [7:0]    i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [7:0]    o_rdata
);
   logic [7:0] mem [0:(1<<AW)-1];
   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// *** mon_chk_properties.sv ***
`timescale 1ns/100ps
module mon_chk
#(
   parameter int SLOT_CYCLES = 20
)
(
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       o_running,
   input wire logic [3:0] o_channel,
   input wire logic       o_int_output_cleared,
   input wire logic       o_int_output_enable
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire cfg_wr = i_reg_wr && (i_reg_addr == mon_pkg::ADDR_CONFIG);
   a_chan_range:
      assert property (o_channel < 4'h9) else $error("channel out of range");
   a_chan_order:
      assert property (!$past(i_rst) && $changed(o_channel) |->
         o_channel == (($past(o_channel) == 4'h8) ? 4'h0 : $past(o_channel) + 4'h1))
      else $error("channel order broken");
   a_slot_hold:
      assert property (!$past(i_rst) && $changed(o_channel) |=> $stable(o_channel) [*8])
      else $error("slot too short");
   a_start_latency:
      assert property (cfg_wr && i_reg_wdata[0] && !i_reg_wdata[3] && !o_running
         |-> ##3 o_running) else $error("loop did not start");
   a_stop_wrap:
      assert property (!$past(i_rst) && $fell(o_running) |-> $past(o_channel, 2) == 4'h8)
      else $error("loop stopped early");
   a_temp_first:
      assert property ($rose(o_running) |-> o_channel == 4'h0) else $error("restart not at 0");
   a_halt_clr:
      assert property ($rose(o_running) |-> !o_int_output_cleared) else $error("ran while clear");
   a_clr_copy:
      assert property (cfg_wr ##1 !i_reg_wr [*2] |->
         o_int_output_cleared == $past(i_reg_wdata[3], 2)) else $error("clear bit lost");
   a_en_copy:
      assert property (cfg_wr ##1 !i_reg_wr [*2] |->
         o_int_output_enable == $past(i_reg_wdata[1], 2)) else $error("enable bit lost");
   c_start: cover property ($rose(o_running));
   c_stop: cover property ($fell(o_running));
   c_wrap: cover property (o_running && o_channel == 4'h0 && $past(o_channel) == 4'h8);
endmodule
bind monitor_loop_sequencer mon_chk #(.SLOT_CYCLES(SLOT_CYCLES)) mon_chk_inst (.*);

// *** analog_front.sv ***
`timescale 1ns/100ps
module analog_front
(
   input  wire logic [2:0] i_set,
   output logic      [7:0] o_code [9]
);
   // rows cover both signs so a wrong sign bit shows
   localparam logic [7:0] TEMPS [5] = '{8'h7d, 8'h19, 8'h00, 8'hff, 8'hd8};
   always_comb
   begin
      o_code[0] = TEMPS[i_set];
      for (int n = 1; n < 9; n++)
      begin
         o_code[n] = 8'hc0 + 8'(n) + {5'h00, i_set};
      end
   end
endmodule

// *** test_monitor_loop_sequencer.sv ***
`timescale 1ns/100ps
module test_monitor_loop_sequencer;
   localparam int SLOT = 20;
   localparam logic [7:0] TEMPS [5] = '{8'h7d, 8'h19, 8'h00, 8'hff, 8'hd8};
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [2:0] sel = 3'h0;
   logic [7:0] code [9];
   logic [7:0] rdata;
   logic       running;
   logic [3:0] channel;
   logic       clr;
   logic       ien;
   int         n_fail = 0;
   int         checks = 0;
   always #12.5 clk = ~clk;
   analog_front analog_front_inst (.i_set(sel), .o_code(code));
   monitor_loop_sequencer #(.SLOT_CYCLES(SLOT)) monitor_loop_sequencer_inst
   (
      .i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_temperature_code(code[0]),
      .i_standby_or_secondary_core_input(code[1]), .i_supply_12v_code(code[2]),
      .i_supply_5v_code(code[3]), .i_supply_3v3_code(code[4]), .i_supply_2v5_code(code[5]),
      .i_primary_core_voltage_input(code[6]), .i_tachometer_one(code[7]),
      .i_tachometer_two(code[8]), .o_running(running), .o_channel(channel),
      .o_int_output_cleared(clr), .o_int_output_enable(ien)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(rdata, exp, "read data");
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      rd_reg(mon_pkg::ADDR_CONFIG, mon_pkg::CONFIG_RESET);
      rd_reg(8'h50, 8'h00);
      for (int s = 0; s < 5; s++)
      begin
         sel = 3'(s);
         repeat (3) @(negedge clk);
         wr_reg(mon_pkg::ADDR_CONFIG, 8'h03);
         // lands mid slot 3, well clear of the slot edges
         repeat (2 + 3 * (SLOT + 1) + 10) @(negedge clk);
         chk({4'h0, channel}, 8'h03, "channel");
         rd_reg(8'h28, 8'hc1 + 8'(s));
         wr_reg(mon_pkg::ADDR_CONFIG, s[0] ? 8'h0b : 8'h02);
         chk({7'h00, running}, 8'h01, "running");
         for (int i = 0; i < 400 && running; i++)
            @(negedge clk);
         chk({7'h00, running}, 8'h00, "stopped");
         chk({6'h00, clr, ien}, {6'h00, s[0], 1'b1}, "int bits");
         rd_reg(mon_pkg::ADDR_TEMPERATURE, TEMPS[s]);
         for (int n = 1; n < 9; n++)
            rd_reg(mon_pkg::ADDR_TEMPERATURE + 8'(n), 8'hc0 + 8'(n + s));
      end
      conclude;
   end
endmodule
